// ===== chassis_power_on_sequencer_tb_top.sv
// chassis_power_on_sequencer_tb_top: self-checking bench for cps_sequencer
// assumes short gaps; supply model closes the monitor loop
`timescale 1ns/1ps
module chassis_power_on_sequencer_tb_top;
  localparam int unsigned G12 = 5;
  localparam int unsigned G23 = 7;
  localparam int unsigned G34 = 3;
  logic       clk_sys_in = 1'b0;
  logic       reset_n_in = 1'b0;
  logic       sel        = 1'b1;
  logic       slot_req   = 1'b0;
  logic       ext_req    = 1'b0;
  logic       fail       = 1'b0;
  logic       sag        = 1'b0;
  logic [2:0] uv;
  logic [3:0] en;
  logic       good;
  logic       busy;
  int         error_cnt  = 0;
  int         n_compared = 0;
  always #2 clk_sys_in = ~clk_sys_in;
  cps_sequencer #(.GAP_1_2_CYC(G12), .GAP_2_3_CYC(G23), .GAP_3_4_CYC(G34)) u_dut (.clk_sys_in,
    .reset_n_in, .request_source_select_in(sel), .slot_power_request_in(slot_req),
    .external_power_request_in(ext_req), .rail_undervolt_in(uv), .power_fail_in(fail),
    .rail_enable_out(en), .power_good_out(good), .sequence_busy_out(busy));
  cps_psu_model u_psu (.clk_sys_in, .rail_enable_in(en), .sag_5v_in(sag), .rail_undervolt_out(uv));
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk_vec(input logic [3:0] got, input logic [3:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_vec({3'h0, got}, {3'h0, exp});
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(negedge clk_sys_in);
  endtask
  // next enable change must come exactly gap falling edges later
  task automatic step(input logic [3:0] exp, input int unsigned gap);
    logic [3:0]  prev;
    int unsigned k;
    prev = en;
    k = 0;
    do begin
      @(negedge clk_sys_in);
      k++;
      if (k > gap + 8) begin
        error_cnt++;
        tally_and_finish();
      end
    end while (en === prev);
    chk_vec(en, exp);
    chk_vec(4'(k), 4'(gap));
  endtask
  // first enable shows one falling edge after the request is taken
  task automatic ramp;
    step(4'h1, 1);
    chk_bit(busy, 1'b1);
    step(4'h3, G12);
    step(4'h7, G23);
    step(4'hF, G34);
    chk_bit(busy, 1'b0);
  endtask
  // slot request ramps the rails; external request has no say
  task automatic t_slot;
    sel = 1'b1;
    ext_req = 1'b1;
    wait_n(1);
    chk_bit(good, 1'b0);
    wait_n(3);
    chk_vec(en, 4'h0);
    slot_req = 1'b1;
    ramp();
    ext_req = 1'b0;
    wait_n(10);
    chk_bit(good, 1'b1);
    chk_vec(en, 4'hF);
    slot_req = 1'b0;
    step(4'h0, 1);
    wait_n(8);
    chk_bit(good, 1'b0);
  endtask
  // external request, dropped mid-ramp, then re-raised at once
  task automatic t_ext;
    sel = 1'b0;
    slot_req = 1'b1;
    wait_n(4);
    chk_vec(en, 4'h0);
    ext_req = 1'b1;
    step(4'h1, 1);
    step(4'h3, G12);
    ext_req = 1'b0;
    step(4'h0, 1);
    ext_req = 1'b1;
    step(4'h1, 1);
    slot_req = 1'b0;
    ext_req = 1'b0;
    step(4'h0, 1);
    chk_bit(busy, 1'b0);
  endtask
  // power fail part-way through the ramp; then sag and fail with rails up
  task automatic t_fail;
    ext_req = 1'b1;
    step(4'h1, 1);
    fail = 1'b1;
    step(4'h0, 3);
    chk_bit(busy, 1'b0);
    ext_req = 1'b0;
    fail = 1'b0;
    wait_n(4);
    ext_req = 1'b1;
    ramp();
    wait_n(10);
    sag = 1'b1;
    wait_n(6);
    chk_bit(good, 1'b0);
    sag = 1'b0;
    wait_n(6);
    chk_bit(good, 1'b1);
    fail = 1'b1;
    wait_n(4);
    chk_vec(en, 4'h0);
    wait_n(6);
    chk_vec(en, 4'h0);
    ext_req = 1'b0;
    fail = 1'b0;
  endtask
  initial begin
    wait_n(16);
    reset_n_in = 1'b1;
    t_slot();
    t_ext();
    t_fail();
    tally_and_finish();
  end
endmodule // chassis_power_on_sequencer_tb_top

// ===== cps_pkg.sv
// cps_pkg: constants for the chassis power-on sequencer
// assumes a 250 MHz system clock; no software-visible registers
package cps_pkg;
  // -----------------------------------------------------------------
  // clock and timing
  // -----------------------------------------------------------------
  localparam int unsigned CLK_FREQ_HZ   = 250_000_000;
  localparam int unsigned GAP_1_2_US    = 1000;  // 1 ms
  localparam int unsigned GAP_2_3_US    = 3000;  // 3 ms
  localparam int unsigned GAP_3_4_US    = 1000;  // 1 ms
  localparam int unsigned CYC_PER_US    = CLK_FREQ_HZ / 1_000_000;
  localparam int unsigned GAP_1_2_CYC   = GAP_1_2_US * CYC_PER_US;
  localparam int unsigned GAP_2_3_CYC   = GAP_2_3_US * CYC_PER_US;
  localparam int unsigned GAP_3_4_CYC   = GAP_3_4_US * CYC_PER_US;
  localparam int unsigned CNT_W         = 20;
  // -----------------------------------------------------------------
  // rail and status layout
  // -----------------------------------------------------------------
  localparam int unsigned RAIL_COUNT    = 4;
  localparam int unsigned RAIL_5V       = 0;
  localparam int unsigned RAIL_P12V     = 1;
  localparam int unsigned RAIL_3V3      = 2;
  localparam int unsigned RAIL_N12V     = 3;
  localparam int unsigned MON_COUNT     = 3;  // under-voltage bits: 3v3, 5v, 12v
  localparam int unsigned MON_3V3       = 0;
  localparam int unsigned MON_5V        = 1;
  localparam int unsigned MON_12V       = 2;
  localparam int unsigned SYNC_STAGES   = 2;
  localparam logic [3:0]  RAILS_OFF     = 4'h0;
  // -----------------------------------------------------------------
  // sequencer states
  // -----------------------------------------------------------------
  typedef enum logic [4:0] {
    CPS_IDLE  = 5'h01,
    CPS_RAIL1 = 5'h02,
    CPS_RAIL2 = 5'h04,
    CPS_RAIL3 = 5'h08,
    CPS_ON    = 5'h10
  } cps_state_e;
endpackage

// ===== cps_psu_model.sv
// cps_psu_model: supply units behind the four rail enables
// assumes enables are levels; reports under-voltage per monitored rail
`timescale 1ns/1ps
module cps_psu_model #(
  parameter int unsigned RISE_CYC = 4
) (
  input  wire logic       clk_sys_in,
  input  wire logic [3:0] rail_enable_in,
  input  wire logic       sag_5v_in,
  output logic      [2:0] rail_undervolt_out
);
  logic [2:0] up_q [RISE_CYC];
  // rails take a few cycles to cross threshold; 12v, 5v, 3v3 order
  always_ff @(posedge clk_sys_in) begin
    up_q[0] <= {rail_enable_in[1], rail_enable_in[0], rail_enable_in[2]};
    for (int i = 1; i < RISE_CYC; i++) begin
      up_q[i] <= up_q[i-1];
    end
  end
  // an off or sagging rail reads as under threshold
  assign rail_undervolt_out = ~up_q[RISE_CYC-1] | {1'b0, sag_5v_in, 1'b0};
endmodule // cps_psu_model

// ===== cps_sequencer.sv
// cps_sequencer: picks the power-on request source, steps four rail enables
// up with timed gaps, and reports power good from rail status
// assumes request pins are synchronous; monitor and fail inputs are async
//
// Behaviour
// - selector high: use slot request, ignore external request
// - selector low: use external request, ignore slot request
// - slot request high with selector high starts rail sequence
// - external request high with selector low starts rail sequence
// - raise enables 1..4 in order, gaps 1 ms, 3 ms, 1 ms
// - enables drive 5 V, +12 V, 3.3 V, -12 V rails respectively
// - request low or power fail shuts the supplies down
// - power good high only when 12 V, 5 V, 3.3 V above thresholds
// - power good low when any of those rails is under threshold
`timescale 1ns/1ps
module cps_sequencer #(
  parameter int unsigned GAP_1_2_CYC = cps_pkg::GAP_1_2_CYC,
  parameter int unsigned GAP_2_3_CYC = cps_pkg::GAP_2_3_CYC,
  parameter int unsigned GAP_3_4_CYC = cps_pkg::GAP_3_4_CYC
) (
  input  wire logic                            clk_sys_in,
  input  wire logic                            reset_n_in,
  input  wire logic                            request_source_select_in,
  input  wire logic                            slot_power_request_in,
  input  wire logic                            external_power_request_in,
  input  wire logic [cps_pkg::MON_COUNT-1:0]   rail_undervolt_in,
  input  wire logic                            power_fail_in,
  output logic [cps_pkg::RAIL_COUNT-1:0]       rail_enable_out,
  output logic                                 power_good_out,
  output logic                                 sequence_busy_out
);
  // -----------------------------------------------------------------
  // synchronise the async status inputs
  // -----------------------------------------------------------------
  localparam int unsigned SW = cps_pkg::MON_COUNT + 1;

  cps_sync_if #(.WIDTH(SW)) sync_bus ();

  assign sync_bus.raw = {power_fail_in, rail_undervolt_in};

  cps_sync #(.WIDTH(SW)) u_sync (
    .clk_sys_in (clk_sys_in),
    .reset_n_in (reset_n_in),
    .bus        (sync_bus)
  );

  logic [cps_pkg::MON_COUNT-1:0] undervolt_s;
  logic                          power_fail_s;

  assign undervolt_s  = sync_bus.synced[cps_pkg::MON_COUNT-1:0];
  assign power_fail_s = sync_bus.synced[cps_pkg::MON_COUNT];

  // -----------------------------------------------------------------
  // synchroniser settle guard
  // -----------------------------------------------------------------
  // the synchronisers leave reset reading all rails healthy and no fail;
  // until real samples reach their outputs nothing starts, power good stays low
  logic [1:0] settle_q;
  logic       settled;

  assign settled = (settle_q == 2'(cps_pkg::SYNC_STAGES));

  // counts the edges since reset, then parks
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      settle_q <= 2'h0;
    end else if (!settled) begin
      settle_q <= settle_q + 2'h1;
    end
  end

  // -----------------------------------------------------------------
  // request source selection
  // -----------------------------------------------------------------
  logic power_on_request;

  // the unselected pin is ignored entirely
  assign power_on_request = request_source_select_in ? slot_power_request_in
                                                     : external_power_request_in;

  // sequence may run only once settled, with a request and no fail
  logic run_ok;
  assign run_ok = settled && power_on_request && !power_fail_s;

  // -----------------------------------------------------------------
  // gap timer
  // -----------------------------------------------------------------
  logic [cps_pkg::CNT_W-1:0] gap_cnt_q;
  logic [cps_pkg::CNT_W-1:0] gap_load;
  logic                      gap_done;

  cps_pkg::cps_state_e state_q;
  cps_pkg::cps_state_e state_d;

  assign gap_done = (gap_cnt_q == '0);

  // reload value for the gap after the rail just raised; a gap of n cycles
  // counts n-1 down to zero so the next rail rises exactly n cycles later
  always_comb begin
    case (state_d)
      cps_pkg::CPS_RAIL1: gap_load = cps_pkg::CNT_W'(GAP_1_2_CYC - 1);
      cps_pkg::CPS_RAIL2: gap_load = cps_pkg::CNT_W'(GAP_2_3_CYC - 1);
      cps_pkg::CPS_RAIL3: gap_load = cps_pkg::CNT_W'(GAP_3_4_CYC - 1);
      default:            gap_load = '0;
    endcase
  end

  // timer reloads on each state change, else counts down to zero
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      gap_cnt_q <= '0;
    end else if (state_d != state_q) begin
      gap_cnt_q <= gap_load;
    end else if (!gap_done) begin
      gap_cnt_q <= gap_cnt_q - cps_pkg::CNT_W'(1);
    end
  end

  // -----------------------------------------------------------------
  // sequencer state machine
  // -----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      cps_pkg::CPS_IDLE: begin
        if (run_ok) begin
          state_d = cps_pkg::CPS_RAIL1;
        end
      end
      cps_pkg::CPS_RAIL1: begin
        if (!run_ok) begin
          state_d = cps_pkg::CPS_IDLE;
        end else if (gap_done) begin
          state_d = cps_pkg::CPS_RAIL2;
        end
      end
      cps_pkg::CPS_RAIL2: begin
        if (!run_ok) begin
          state_d = cps_pkg::CPS_IDLE;
        end else if (gap_done) begin
          state_d = cps_pkg::CPS_RAIL3;
        end
      end
      cps_pkg::CPS_RAIL3: begin
        if (!run_ok) begin
          state_d = cps_pkg::CPS_IDLE;
        end else if (gap_done) begin
          state_d = cps_pkg::CPS_ON;
        end
      end
      cps_pkg::CPS_ON: begin
        if (!run_ok) begin
          state_d = cps_pkg::CPS_IDLE;
        end
      end
      default: begin
        state_d = cps_pkg::CPS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      state_q <= cps_pkg::CPS_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // -----------------------------------------------------------------
  // rail enable outputs
  // -----------------------------------------------------------------
  logic [cps_pkg::RAIL_COUNT-1:0] rail_en_q;

  // registered from the next state so enables track the state exactly;
  // all rails drop together on shutdown, the supply handles ramp-down
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      rail_en_q <= cps_pkg::RAILS_OFF;
    end else begin
      rail_en_q <= cps_pkg::RAILS_OFF;
      case (state_d)
        cps_pkg::CPS_RAIL1: begin
          rail_en_q[cps_pkg::RAIL_5V] <= 1'b1;
        end
        cps_pkg::CPS_RAIL2: begin
          rail_en_q[cps_pkg::RAIL_5V]   <= 1'b1;
          rail_en_q[cps_pkg::RAIL_P12V] <= 1'b1;
        end
        cps_pkg::CPS_RAIL3: begin
          rail_en_q[cps_pkg::RAIL_5V]   <= 1'b1;
          rail_en_q[cps_pkg::RAIL_P12V] <= 1'b1;
          rail_en_q[cps_pkg::RAIL_3V3]  <= 1'b1;
        end
        cps_pkg::CPS_ON: begin
          rail_en_q <= {cps_pkg::RAIL_COUNT{1'b1}}; // -12 V last
        end
        default: begin
          rail_en_q <= cps_pkg::RAILS_OFF;
        end
      endcase
    end
  end

  assign rail_enable_out = rail_en_q;

  // -----------------------------------------------------------------
  // power good
  // -----------------------------------------------------------------
  logic power_good_q;

  // only the three monitored rails count; -12 V has no threshold here
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      power_good_q <= 1'b0;
    end else begin
      power_good_q <= settled && ~|undervolt_s;
    end
  end

  assign power_good_out    = power_good_q;
  assign sequence_busy_out = (state_q != cps_pkg::CPS_IDLE) && (state_q != cps_pkg::CPS_ON);
endmodule // cps_sequencer

// ===== cps_sequencer_checker.sv
// cps_sequencer_checker: port-level assertions for cps_sequencer
// assumes a bind into cps_sequencer; one clock domain
`timescale 1ns/1ps
module cps_sequencer_checker #(
  parameter int unsigned GAP_1_2_CYC = cps_pkg::GAP_1_2_CYC,
  parameter int unsigned GAP_2_3_CYC = cps_pkg::GAP_2_3_CYC,
  parameter int unsigned GAP_3_4_CYC = cps_pkg::GAP_3_4_CYC
) (
  input wire logic       clk_sys_in,
  input wire logic       reset_n_in,
  input wire logic       request_source_select_in,
  input wire logic       slot_power_request_in,
  input wire logic       external_power_request_in,
  input wire logic [2:0] rail_undervolt_in,
  input wire logic       power_fail_in,
  input wire logic [3:0] rail_enable_out,
  input wire logic       power_good_out,
  input wire logic       sequence_busy_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in);
  logic        req_sel;
  logic [3:0]  en_prev_q;
  logic [19:0] hold_q;
  // the request that the selector makes live
  assign req_sel = request_source_select_in ? slot_power_request_in : external_power_request_in;
  // how long the enable pattern has held, so gaps can be measured
  always_ff @(posedge clk_sys_in) begin
    en_prev_q <= reset_n_in ? rail_enable_out : 4'h0;
    hold_q    <= (!reset_n_in || rail_enable_out != en_prev_q) ? 20'h1 : hold_q + 20'h1;
  end
  // fail input must be quiet long enough to clear the synchroniser
  sequence s_fail_quiet;
    (!power_fail_in)[*3];
  endsequence
  sequence s_rails_ok;
    (rail_undervolt_in == 3'h0)[*4];
  endsequence
  a_start_rail_one: assert property (s_fail_quiet ##0 (req_sel && rail_enable_out == 4'h0)
    |=> rail_enable_out == 4'h1) else $error("first rail enable missing");
  a_unselected_ignored: assert property (!req_sel && rail_enable_out == 4'h0 |=>
    rail_enable_out == 4'h0) else $error("enables rose without request");
  a_drop_clears_rails: assert property (!req_sel && rail_enable_out != 4'h0 |=>
    rail_enable_out == 4'h0) else $error("enables kept after request drop");
  a_fail_clears_rails: assert property (power_fail_in[*5] |-> rail_enable_out == 4'h0)
    else $error("enables kept during power fail");
  a_gap_one_two: assert property ($rose(rail_enable_out[1]) |->
    hold_q == GAP_1_2_CYC && rail_enable_out == 4'h3) else $error("second enable mistimed");
  a_gap_two_three: assert property ($rose(rail_enable_out[2]) |->
    hold_q == GAP_2_3_CYC && rail_enable_out == 4'h7) else $error("third enable mistimed");
  a_gap_three_four: assert property ($rose(rail_enable_out[3]) |->
    hold_q == GAP_3_4_CYC && rail_enable_out == 4'hF) else $error("fourth enable mistimed");
  a_good_when_ok: assert property (s_rails_ok |-> power_good_out)
    else $error("power good low with rails up");
  a_good_low_sag: assert property ((|rail_undervolt_in)[*4] |-> !power_good_out)
    else $error("power good high with rail low");
  // busy only while part of the rails are up
  a_busy_in_ramp: assert property (sequence_busy_out ==
    (rail_enable_out != 4'h0 && rail_enable_out != 4'hF)) else $error("busy flag disagrees with enables");
endmodule // cps_sequencer_checker
bind cps_sequencer cps_sequencer_checker #(.GAP_1_2_CYC(GAP_1_2_CYC), .GAP_2_3_CYC(GAP_2_3_CYC),
  .GAP_3_4_CYC(GAP_3_4_CYC)) u_chk (.clk_sys_in, .reset_n_in, .request_source_select_in,
  .slot_power_request_in, .external_power_request_in, .rail_undervolt_in, .power_fail_in,
  .rail_enable_out, .power_good_out, .sequence_busy_out);

// ===== cps_sync.sv
// cps_sync: bank of two-flop synchronisers
// assumes inputs are levels, slower than the clock
`timescale 1ns/1ps
module cps_sync #(
  parameter int unsigned WIDTH = 4
) (
  input  wire logic clk_sys_in,
  input  wire logic reset_n_in,
  cps_sync_if.snk   bus
);
  // -----------------------------------------------------------------
  // synchroniser stages
  // -----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      logic meta_q;
      logic sync_q;
      // first flop feeds only the second one
      always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
          meta_q <= 1'b0;
          sync_q <= 1'b0;
        end else begin
          meta_q <= bus.raw[g];
          sync_q <= meta_q;
        end
      end
      assign bus.synced[g] = sync_q;
    end
  endgenerate
endmodule // cps_sync

// ===== cps_sync_if.sv
// cps_sync_if: bundle of raw async status bits and their synchronised copies
// assumes one clock shared by both ends
`timescale 1ns/1ps
interface cps_sync_if #(parameter int unsigned WIDTH = 4);
  logic [WIDTH-1:0] raw;
  logic [WIDTH-1:0] synced;
  modport src (output raw, input synced);
  modport snk (input raw, output synced);
endinterface
